/* logic/nvm_autoload_pkg.sv */
`default_nettype none
// Shared constants of the nonvolatile autoload controller.
package nvm_autoload_pkg;

	// Word addresses in the nonvolatile memory, counted from its start.
	localparam int             NVM_AW    = 7;
	localparam logic [6:0]     W_ADDR0   = 7'h00;
	localparam logic [6:0]     W_ADDR1   = 7'h01;
	localparam logic [6:0]     W_ADDR2   = 7'h02;
	localparam logic [6:0]     W_CTRL1   = 7'h0a;
	localparam logic [6:0]     W_SUBSYS  = 7'h0b;
	localparam logic [6:0]     W_SUBVEN  = 7'h0c;
	localparam logic [6:0]     W_DEVID   = 7'h0d;
	localparam logic [6:0]     W_VENID   = 7'h0e;
	localparam logic [2:0]     LAST_IDX  = 3'h7;

	// Field positions inside control word one.
	localparam int             CW1_GLOBAL_PARITY_ENABLE = 14;
	localparam int             CW1_HOST_FW_BLOCK        = 11;
	localparam int             CW1_PIN_HOLD             = 6;
	localparam int             CW1_PLL_SHUTDOWN         = 4;
	localparam int             CW1_PM_FULL              = 3;
	localparam int             CW1_DMA_CG_DISABLE       = 2;
	localparam int             CW1_LOAD_SUBSYS          = 1;
	localparam int             CW1_LOAD_VEN_DEV         = 0;
	// Control word one as it reads before any load.
	localparam logic [15:0]    CW1_RESET    = 16'h602f;
	// A blank vendor word, which must never reach the host.
	localparam logic [15:0]    VENDOR_BLANK = 16'hffff;

	// Register map on the AXI4-Lite slave.
	localparam int             AXI_AW      = 8;
	localparam logic [7:0]     REG_CTRL    = 8'h00;
	localparam logic [7:0]     REG_STATUS  = 8'h04;
	localparam logic [7:0]     REG_CW1     = 8'h08;
	localparam logic [7:0]     REG_ADDR_LO = 8'h0c;
	localparam logic [7:0]     REG_ADDR_HI = 8'h10;
	localparam logic [7:0]     REG_IDS     = 8'h14;
	localparam logic [7:0]     REG_SUBSYS  = 8'h18;
	localparam int             CTRL_SWRST  = 0;
	localparam int             CW1_REG_PARITY = 16;
	localparam logic [1:0]     RESP_OKAY   = 2'h0;
	localparam logic [1:0]     RESP_SLVERR = 2'h2;

	// Loader sequence states.
	typedef enum logic [1:0] {
		LD_IDLE,
		LD_ISSUE,
		LD_WAIT
	} ld_state_e;

endpackage
`default_nettype wire

/* logic/nvm_rd_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Word read request from the loader to the memory reader.
interface nvm_rd_if;
	import nvm_autoload_pkg::*;
	logic              start;  // One-cycle request for one word.
	logic [NVM_AW-1:0] addr;   // Word address, valid with start.
	logic              done;   // One-cycle pulse, data valid.
	logic [15:0]       data;   // Word read.
	modport requester (output start, output addr, input done, input data);
	modport reader    (input start, input addr, output done, output data);
endinterface
`default_nettype wire

/* logic/nvm_word_reader.sv */
`timescale 1ns/1ps
`default_nettype none
// Holds one read request on the memory pins until the memory answers.
module nvm_word_reader
	import nvm_autoload_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              nrst_in,
	nvm_rd_if.reader               rd,
	output logic                   nvm_rd_out,
	output logic [NVM_AW-1:0]      nvm_addr_out,
	input  wire logic [15:0]       nvm_data_in,
	input  wire logic              nvm_valid_in
);

	// All state of the reader.
	typedef struct packed {
		logic              busy;  // Request is on the pins.
		logic [NVM_AW-1:0] addr;  // Address held on the pins.
		logic              done;  // Answer pulse to the loader.
		logic [15:0]       data;  // Captured word.
	} rd_state_s;

	rd_state_s r;
	rd_state_s r_nxt;

	//////////////////////////////////////////////////////////////////////////
	// A new request is taken only while idle; the memory may answer in any
	// later cycle, so no latency is assumed here.
	always_comb begin
		r_nxt      = r;
		r_nxt.done = 1'b0;
		if (!r.busy && rd.start) begin
			r_nxt.busy = 1'b1;
			r_nxt.addr = rd.addr;
		end else if (r.busy && nvm_valid_in) begin
			r_nxt.busy = 1'b0;
			r_nxt.done = 1'b1;
			r_nxt.data = nvm_data_in;
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign nvm_rd_out   = r.busy;
	assign nvm_addr_out = r.addr;
	assign rd.done      = r.done;
	assign rd.data      = r.data;

endmodule
`default_nettype wire

/* logic/nvm_autoload_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module nvm_autoload_ctrl
	import nvm_autoload_pkg::*;
#(
	parameter logic [15:0] DEF_VENDOR_ID = 16'h5a3c,  // Arbitrary value.
	parameter logic [15:0] DEF_DEVICE_ID = 16'h7e21,  // Arbitrary value.
	parameter logic [15:0] DEF_SUBSYS_ID = 16'h0101   // Arbitrary value.
) (
	input  wire logic              CORE_CLK_IN,
	input  wire logic              NRST_IN,
	input  wire logic              LAN_POWER_GOOD_IN,
	input  wire logic              DDOFF_MODE_EN_IN,
	output logic                   NVM_RD_OUT,
	output logic [NVM_AW-1:0]      NVM_ADDR_OUT,
	input  wire logic [15:0]       NVM_DATA_IN,
	input  wire logic              NVM_VALID_IN,
	output logic [47:0]            RX_ADDR0_OUT,
	output logic                   GLOBAL_PARITY_ENABLE_OUT,
	output logic                   HOST_FW_DOWNLOAD_BLOCK_OUT,
	output logic                   PIN_HOLD_IN_DEVICE_OFF_OUT,
	output logic                   PLL_SHUTDOWN_EN_OUT,
	output logic                   PM_REGS_WRITABLE_OUT,
	output logic                   D3_HW_TRANSITION_EN_OUT,
	output logic                   DMA_CG_DISABLE_OUT,
	output logic [15:0]            VENDOR_ID_OUT,
	output logic [15:0]            DEVICE_ID_OUT,
	output logic [15:0]            SUBSYS_ID_OUT,
	output logic [15:0]            SUBSYS_VENDOR_ID_OUT,
	output logic                   CFG_RETRY_OUT,
	input  wire logic [AXI_AW-1:0] AXI_AWADDR_IN,
	input  wire logic              AXI_AWVALID_IN,
	output logic                   AXI_AWREADY_OUT,
	input  wire logic [31:0]       AXI_WDATA_IN,
	input  wire logic [3:0]        AXI_WSTRB_IN,
	input  wire logic              AXI_WVALID_IN,
	output logic                   AXI_WREADY_OUT,
	output logic [1:0]             AXI_BRESP_OUT,
	output logic                   AXI_BVALID_OUT,
	input  wire logic              AXI_BREADY_IN,
	input  wire logic [AXI_AW-1:0] AXI_ARADDR_IN,
	input  wire logic              AXI_ARVALID_IN,
	output logic                   AXI_ARREADY_OUT,
	output logic [31:0]            AXI_RDATA_OUT,
	output logic [1:0]             AXI_RRESP_OUT,
	output logic                   AXI_RVALID_OUT,
	input  wire logic              AXI_RREADY_IN
);

	//////////////////////////////////////////////////////////////////////////
	// All state of the controller in one record.
	typedef struct packed {
		ld_state_e         st;        // Loader sequence state.
		logic [2:0]        idx;       // Position in the word sequence.
		logic              pg;        // Current load follows power-good.
		logic              pend;      // A load is requested.
		logic              pend_pg;   // The requested load is power-good.
		logic              loaded;    // At least one load has finished.
		logic [15:0]       cw1;       // Control word one as loaded.
		logic              parity;    // Global parity enable.
		logic              pin_hold;  // Pin hold, qualified by device-off.
		logic [47:0]       mac;       // Station address, byte 0 lowest.
		logic [15:0]       ven;       // Vendor identifier.
		logic [15:0]       dev;       // Device identifier.
		logic [15:0]       sub;       // Subsystem identifier.
		logic [15:0]       subven;    // Subsystem vendor identifier.
		logic              aw_got;    // Write address taken.
		logic              w_got;     // Write data taken.
		logic [AXI_AW-1:0] awaddr;    // Held write address.
		logic [31:0]       wdata;     // Held write data.
		logic [3:0]        wstrb;     // Held byte enables.
		logic              bvalid;    // Write response pending.
		logic [1:0]        bresp;     // Write response code.
		logic              rvalid;    // Read data pending.
		logic [31:0]       rdata;     // Read data.
		logic [1:0]        rresp;     // Read response code.
	} ctl_state_s;

	ctl_state_s r;
	ctl_state_s r_nxt;
	logic       wr_fire;    // Both write halves held, response free.
	logic       sw_trig;    // Software asks for a reload.
	logic       word_done;  // A word arrived for the loader.

	nvm_rd_if rd ();

	//////////////////////////////////////////////////////////////////////////
	// Sequence position to absolute word address; the loader never uses
	// section-relative offsets, so no base is added.
	function automatic logic [NVM_AW-1:0] word_addr(input logic [2:0] idx);
		unique case (idx)
			3'h0: word_addr = W_ADDR0;
			3'h1: word_addr = W_ADDR1;
			3'h2: word_addr = W_ADDR2;
			3'h3: word_addr = W_CTRL1;
			3'h4: word_addr = W_SUBSYS;
			3'h5: word_addr = W_SUBVEN;
			3'h6: word_addr = W_DEVID;
			3'h7: word_addr = W_VENID;
		endcase
	endfunction

	// True for every byte address that holds a register.
	function automatic logic reg_mapped(input logic [AXI_AW-1:0] a);
		reg_mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_CW1) ||
			(a == REG_ADDR_LO) || (a == REG_ADDR_HI) || (a == REG_IDS) || (a == REG_SUBSYS);
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// The memory reader owns the pins; the loader only issues words.
	nvm_word_reader u_reader (
		.clk_in       (CORE_CLK_IN),
		.nrst_in      (NRST_IN),
		.rd           (rd),
		.nvm_rd_out   (NVM_RD_OUT),
		.nvm_addr_out (NVM_ADDR_OUT),
		.nvm_data_in  (NVM_DATA_IN),
		.nvm_valid_in (NVM_VALID_IN)
	);

	assign rd.start  = (r.st == LD_ISSUE);
	assign rd.addr   = word_addr(r.idx);
	assign word_done = (r.st == LD_WAIT) && rd.done;
	assign wr_fire   = r.aw_got && r.w_got && !r.bvalid;
	assign sw_trig   = wr_fire && (r.awaddr == REG_CTRL) && r.wstrb[0] &&
		r.wdata[CTRL_SWRST];

	//////////////////////////////////////////////////////////////////////////
	// Next state: loader sequence, then the bus slave, then load requests.
	always_comb begin
		r_nxt = r;
		unique case (r.st)
			// Start a pending load; identifiers fall back to defaults first
			// so that a clear load bit leaves the built-in value.
			LD_IDLE: begin
				if (r.pend) begin
					r_nxt.st      = LD_ISSUE;
					r_nxt.idx     = 3'h0;
					r_nxt.pg      = r.pend_pg;
					r_nxt.pend    = 1'b0;
					r_nxt.pend_pg = 1'b0;
					r_nxt.ven     = DEF_VENDOR_ID;
					r_nxt.dev     = DEF_DEVICE_ID;
					r_nxt.sub     = DEF_SUBSYS_ID;
					r_nxt.subven  = DEF_VENDOR_ID;
				end
			end
			// The reader takes the request in this cycle.
			LD_ISSUE: begin
				r_nxt.st = LD_WAIT;
			end
			// Apply each word as it arrives.
			LD_WAIT: begin
				if (rd.done) begin
					unique case (r.idx)
						3'h0: r_nxt.mac[15:0]  = rd.data;
						3'h1: r_nxt.mac[31:16] = rd.data;
						3'h2: r_nxt.mac[47:32] = rd.data;
						3'h3: begin
							r_nxt.cw1 = rd.data;
							// Parity follows only power-good loads.
							if (r.pg) begin
								r_nxt.parity = rd.data[CW1_GLOBAL_PARITY_ENABLE];
							end
						end
						3'h4: if (r.cw1[CW1_LOAD_SUBSYS]) begin
							r_nxt.sub = rd.data;
						end
						3'h5: if (r.cw1[CW1_LOAD_SUBSYS]) begin
							r_nxt.subven = rd.data;
						end
						3'h6: if (r.cw1[CW1_LOAD_VEN_DEV]) begin
							r_nxt.dev = rd.data;
						end
						// A blank vendor word would hang enumeration.
						3'h7: if (r.cw1[CW1_LOAD_VEN_DEV] && rd.data != VENDOR_BLANK) begin
							r_nxt.ven = rd.data;
						end
					endcase
					if (r.idx == LAST_IDX) begin
						r_nxt.st     = LD_IDLE;
						r_nxt.loaded = 1'b1;
					end else begin
						r_nxt.idx = r.idx + 3'h1;
						r_nxt.st  = LD_ISSUE;
					end
				end
			end
		endcase

		// Pin hold only matters while device-off mode is enabled.
		r_nxt.pin_hold = r.cw1[CW1_PIN_HOLD] && DDOFF_MODE_EN_IN;

		// Write channels are taken in either order and held until answered.
		if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
			r_nxt.aw_got = 1'b1;
			r_nxt.awaddr = AXI_AWADDR_IN;
		end
		if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
			r_nxt.w_got = 1'b1;
			r_nxt.wdata = AXI_WDATA_IN;
			r_nxt.wstrb = AXI_WSTRB_IN;
		end
		if (wr_fire) begin
			r_nxt.bvalid = 1'b1;
			r_nxt.bresp  = reg_mapped(r.awaddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (r.bvalid && AXI_BREADY_IN) begin
			r_nxt.bvalid = 1'b0;
			r_nxt.aw_got = 1'b0;
			r_nxt.w_got  = 1'b0;
		end

		// Reads are answered one cycle after the address is taken.
		if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
			r_nxt.rvalid = 1'b1;
			r_nxt.rresp  = reg_mapped(AXI_ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
			unique case (AXI_ARADDR_IN)
				REG_STATUS:  r_nxt.rdata = {29'h0, r.pg, r.loaded, r.st != LD_IDLE};
				REG_CW1:     r_nxt.rdata = {15'h0, r.parity, r.cw1};
				REG_ADDR_LO: r_nxt.rdata = r.mac[31:0];
				REG_ADDR_HI: r_nxt.rdata = {16'h0, r.mac[47:32]};
				REG_IDS:     r_nxt.rdata = {r.dev, r.ven};
				REG_SUBSYS:  r_nxt.rdata = {r.sub, r.subven};
				default:     r_nxt.rdata = 32'h0;
			endcase
		end else if (r.rvalid && AXI_RREADY_IN) begin
			r_nxt.rvalid = 1'b0;
		end

		// Load requests come last so a request in the cycle that consumes
		// the previous one is kept rather than lost.
		if (LAN_POWER_GOOD_IN) begin
			r_nxt.pend    = 1'b1;
			r_nxt.pend_pg = 1'b1;
		end
		if (sw_trig) begin
			r_nxt.pend = 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Reset starts a power-up load at once, with defaults in place.
	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			r        <= '0;
			r.st     <= LD_ISSUE;
			r.pg     <= 1'b1;
			r.cw1    <= CW1_RESET;
			r.ven    <= DEF_VENDOR_ID;
			r.dev    <= DEF_DEVICE_ID;
			r.sub    <= DEF_SUBSYS_ID;
			r.subven <= DEF_VENDOR_ID;
		end else begin
			r <= r_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs; all data outputs come straight from the state register.
	assign RX_ADDR0_OUT               = r.mac;
	assign GLOBAL_PARITY_ENABLE_OUT   = r.parity;
	assign HOST_FW_DOWNLOAD_BLOCK_OUT = r.cw1[CW1_HOST_FW_BLOCK];
	assign PIN_HOLD_IN_DEVICE_OFF_OUT = r.pin_hold;
	assign PLL_SHUTDOWN_EN_OUT        = r.cw1[CW1_PLL_SHUTDOWN];
	assign PM_REGS_WRITABLE_OUT       = r.cw1[CW1_PM_FULL];
	assign D3_HW_TRANSITION_EN_OUT    = r.cw1[CW1_PM_FULL];
	assign DMA_CG_DISABLE_OUT         = r.cw1[CW1_DMA_CG_DISABLE];
	assign VENDOR_ID_OUT              = r.ven;
	assign DEVICE_ID_OUT              = r.dev;
	assign SUBSYS_ID_OUT              = r.sub;
	assign SUBSYS_VENDOR_ID_OUT       = r.subven;
	// The host sees retry while a load runs or waits to run.
	assign CFG_RETRY_OUT              = (r.st != LD_IDLE) || r.pend;
	assign AXI_AWREADY_OUT            = !r.aw_got && !r.bvalid;
	assign AXI_WREADY_OUT             = !r.w_got && !r.bvalid;
	assign AXI_BVALID_OUT             = r.bvalid;
	assign AXI_BRESP_OUT              = r.bresp;
	assign AXI_ARREADY_OUT            = !r.rvalid;
	assign AXI_RVALID_OUT             = r.rvalid;
	assign AXI_RDATA_OUT              = r.rdata;
	assign AXI_RRESP_OUT              = r.rresp;

	//////////////////////////////////////////////////////////////////////////
	// Checks on the loader.
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!NRST_IN);
	property p_addr_low;
		word_done && r.idx == 3'h0 |=> RX_ADDR0_OUT[15:0] == $past(rd.data);
	endproperty
	a_addr_low: assert property (p_addr_low) else $error("Address word 0 lost.");
	property p_addr_order;
		word_done && r.idx == 3'h2 |=> RX_ADDR0_OUT[47:40] == $past(rd.data[15:8]);
	endproperty
	a_addr_order: assert property (p_addr_order) else $error("Address byte order.");
	property p_abs_addr;
		r.st == LD_ISSUE && r.idx == 3'h3 |=> NVM_RD_OUT && NVM_ADDR_OUT == W_CTRL1;
	endproperty
	a_abs_addr: assert property (p_abs_addr) else $error("Wrong word address.");
	property p_parity_pg;
		word_done && r.idx == 3'h3 && !r.pg |=> $stable(GLOBAL_PARITY_ENABLE_OUT);
	endproperty
	a_parity_pg: assert property (p_parity_pg) else $error("Parity loaded late.");
	property p_fw_block;
		word_done && r.idx == 3'h3 |=>
			HOST_FW_DOWNLOAD_BLOCK_OUT == $past(rd.data[CW1_HOST_FW_BLOCK]);
	endproperty
	a_fw_block: assert property (p_fw_block) else $error("Download block wrong.");
	property p_pin_hold;
		!DDOFF_MODE_EN_IN |=> !PIN_HOLD_IN_DEVICE_OFF_OUT;
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("Pin hold not gated.");
	property p_pm;
		word_done && r.idx == 3'h3 && !rd.data[CW1_PM_FULL] |=>
			!PM_REGS_WRITABLE_OUT && !D3_HW_TRANSITION_EN_OUT;
	endproperty
	a_pm: assert property (p_pm) else $error("Power management not locked.");
	property p_sub_load;
		word_done && r.idx == 3'h4 && r.cw1[CW1_LOAD_SUBSYS] |=>
			SUBSYS_ID_OUT == $past(rd.data);
	endproperty
	a_sub_load: assert property (p_sub_load) else $error("Subsystem not loaded.");
	property p_sub_default;
		word_done && r.idx == 3'h5 && !r.cw1[CW1_LOAD_SUBSYS] |=>
			SUBSYS_ID_OUT == DEF_SUBSYS_ID && SUBSYS_VENDOR_ID_OUT == DEF_VENDOR_ID;
	endproperty
	a_sub_default: assert property (p_sub_default) else $error("Subsystem default lost.");
	property p_dev_default;
		word_done && r.idx == 3'h6 && !r.cw1[CW1_LOAD_VEN_DEV] |=>
			DEVICE_ID_OUT == DEF_DEVICE_ID;
	endproperty
	a_dev_default: assert property (p_dev_default) else $error("Device default lost.");
	property p_sw_load;
		sw_trig && r.st == LD_IDLE && !r.pend |-> ##2 r.st == LD_ISSUE;
	endproperty
	a_sw_load: assert property (p_sw_load) else $error("Software reload missing.");
	property p_blank_vendor;
		word_done && r.idx == 3'h7 && rd.data == VENDOR_BLANK |=> VENDOR_ID_OUT == DEF_VENDOR_ID;
	endproperty
	a_blank_vendor: assert property (p_blank_vendor) else $error("Blank vendor used.");
	// Retry may only end right after the last word of a load was applied.
	property p_retry;
		$fell(CFG_RETRY_OUT) |-> $past(word_done) && $past(r.idx) == LAST_IDX;
	endproperty
	a_retry: assert property (p_retry) else $error("Retry dropped before load end.");

	c_full_load: cover property (word_done && r.idx == LAST_IDX);
	c_blank_vendor: cover property (word_done && r.idx == 3'h7 && rd.data == VENDOR_BLANK);
	c_sw_reload: cover property (sw_trig);
	c_bus_error: cover property (AXI_BVALID_OUT && AXI_BRESP_OUT == RESP_SLVERR);
endmodule
`default_nettype wire

/* bench/nvm_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Memory image on the far side; answers each request after a set delay.
module nvm_mem_model
	import nvm_autoload_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rd_in,
	input  wire logic [NVM_AW-1:0] addr_in,
	output logic      [15:0]       data_out,
	output logic                   valid_out
);
	logic [15:0] mem [0:127];  // Word image, filled by the bench.
	int          delay = 0;    // Wait cycles before each answer.
	int          cnt   = 0;    // Cycles waited on the current request.
	initial begin
		data_out  = 16'h0000;
		valid_out = 1'b0;
	end
	// Outside an answer the data toggles, so a stale word never passes for a fresh one.
	always @(posedge clk_in) begin
		if (rd_in && !valid_out && cnt >= delay) begin
			valid_out <= 1'b1;
			data_out  <= mem[addr_in];
		end else begin
			valid_out <= 1'b0;
			data_out  <= ~data_out;
			cnt       <= (rd_in && !valid_out) ? cnt + 1 : 0;
		end
	end
endmodule
`default_nettype wire

/* bench/test_nvm_autoload_identity_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module test_nvm_autoload_identity_ctrl
	import nvm_autoload_pkg::*;
;
	localparam logic [6:0] ORDER [8] = '{W_ADDR0, W_ADDR1, W_ADDR2, W_CTRL1,
		W_SUBSYS, W_SUBVEN, W_DEVID, W_VENID};  // Expected word fetch order.
	logic        clk = 1'b0, nrst = 1'b0, pg = 1'b0, ddoff = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	logic        nvm_rd, nvm_valid, gpe, hfb, pin, pll, pmw, d3, dma, retry;
	logic [6:0]  nvm_addr;
	logic [15:0] nvm_data, ven, dev, sub, subv;
	logic [47:0] rx_addr;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rsp;
	logic [31:0] rdata, rd_d;
	int          errors = 0, tests_run = 0, idx = 0;

	nvm_autoload_ctrl nvm_autoload_ctrl_inst (
		.CORE_CLK_IN(clk), .NRST_IN(nrst), .LAN_POWER_GOOD_IN(pg), .DDOFF_MODE_EN_IN(ddoff),
		.NVM_RD_OUT(nvm_rd), .NVM_ADDR_OUT(nvm_addr), .NVM_DATA_IN(nvm_data),
		.NVM_VALID_IN(nvm_valid), .RX_ADDR0_OUT(rx_addr), .GLOBAL_PARITY_ENABLE_OUT(gpe),
		.HOST_FW_DOWNLOAD_BLOCK_OUT(hfb), .PIN_HOLD_IN_DEVICE_OFF_OUT(pin),
		.PLL_SHUTDOWN_EN_OUT(pll), .PM_REGS_WRITABLE_OUT(pmw), .D3_HW_TRANSITION_EN_OUT(d3),
		.DMA_CG_DISABLE_OUT(dma), .VENDOR_ID_OUT(ven), .DEVICE_ID_OUT(dev),
		.SUBSYS_ID_OUT(sub), .SUBSYS_VENDOR_ID_OUT(subv), .CFG_RETRY_OUT(retry),
		.AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awready),
		.AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hf), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wready),
		.AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
		.AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arready),
		.AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid),
		.AXI_RREADY_IN(rready)
	);
	nvm_mem_model nvm_mem_model_inst (
		.clk_in(clk), .rd_in(nvm_rd), .addr_in(nvm_addr), .data_out(nvm_data),
		.valid_out(nvm_valid)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Compare, bus and load tasks; automatic so the fetch monitor may share them.
	task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk_val({62'h0, got}, {62'h0, exp});
	endtask
	task automatic results;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Address and data go out together; each is dropped at the edge that takes it.
	// No answer time is assumed: only the watchdog ends a wait.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata  <= d;
		awv    <= 1'b1;
		wv     <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready) awv <= 1'b0;
			if (wready) wv <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arv    <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready) arv <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask
	// Waits up to 50 cycles for the retry flag to rise, then checks that it drops once every word is applied.
	task automatic wait_load;
		int n;
		for (n = 0; n < 50 && retry !== 1'b1; n++) @(posedge clk);
		for (n = 0; n < 2000 && retry !== 1'b0; n++) @(posedge clk);
		chk_val(retry, 64'h0);
	endtask
	// Fills the image; the station address goes low byte first, word by word.
	task automatic set_img(input logic [47:0] mac, input logic [15:0] cw, input logic [15:0] vd);
		nvm_mem_model_inst.mem[W_ADDR0] = mac[15:0];
		nvm_mem_model_inst.mem[W_ADDR1] = mac[31:16];
		nvm_mem_model_inst.mem[W_ADDR2] = mac[47:32];
		nvm_mem_model_inst.mem[W_CTRL1] = cw;
		nvm_mem_model_inst.mem[W_SUBSYS] = 16'h1b1b;
		nvm_mem_model_inst.mem[W_SUBVEN] = 16'h1c1c;
		nvm_mem_model_inst.mem[W_DEVID] = 16'h1d1d;
		nvm_mem_model_inst.mem[W_VENID] = vd;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock, fetch-order monitor and watchdog.
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		if (nvm_rd && nvm_valid) begin
			chk_val(nvm_addr, ORDER[idx]);
			idx = (idx + 1) % 8;
		end
	end
	initial begin
		#(40 * 5000);
		errors++;
		results;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset load, software reload, power-good load, hardware reset.
	initial begin
		set_img(48'h665544332211, 16'h485f, 16'h1e1e);
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		chk_val(retry, 64'h1);
		wait_load;
		chk_val(rx_addr, 48'h665544332211);
		chk_val({gpe, hfb, pin, pll, pmw, d3, dma}, 7'h7f);
		chk_val({ven, dev, sub, subv}, 64'h1e1e1d1d1b1b1c1c);
		axi_rd(REG_CW1, rd_d, rsp);
		chk_val(rd_d, 32'h0001485f);
		axi_rd(8'h1c, rd_d, rsp);
		chk_resp(rsp, RESP_SLVERR);
		chk_val(rd_d, 32'h0);
		axi_wr(REG_IDS, 32'h0, rsp);
		chk_resp(rsp, RESP_OKAY);
		axi_rd(REG_IDS, rd_d, rsp);
		chk_val(rd_d, 32'h1d1d1e1e);
		ddoff <= 1'b0;
		repeat (3) @(posedge clk);
		chk_val(pin, 64'h0);
		// The image breaks the parity rule on purpose: a software load must not copy it.
		set_img(48'hccddeeff0011, 16'h0000, 16'h1e1e);
		axi_wr(REG_CTRL, 32'h1, rsp);
		wait_load;
		chk_val(rx_addr, 48'hccddeeff0011);
		chk_val({gpe, hfb, pin, pll, pmw, d3, dma}, 7'h40);
		chk_val({ven, dev, sub, subv}, 64'h5a3c7e2101015a3c);
		// Slow memory, blank vendor word, parity cleared on a power-good load.
		nvm_mem_model_inst.delay = 3;
		set_img(48'hccddeeff0011, 16'h0003, 16'hffff);
		pg <= 1'b1;
		@(posedge clk);
		pg <= 1'b0;
		wait_load;
		chk_val(gpe, 64'h0);
		chk_val({ven, dev, sub, subv}, 64'h5a3c1d1d1b1b1c1c);
		// A hardware reset while the loader is idle loads again and counts as power-good.
		set_img(48'h665544332211, 16'h4000, 16'h1e1e);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		wait_load;
		chk_val({rx_addr, gpe, pmw}, {48'h665544332211, 2'b10});
		chk_val({ven, dev, sub, subv}, 64'h5a3c7e2101015a3c);
		// Status after the reset load: power-good load, loaded once, idle.
		axi_rd(REG_STATUS, rd_d, rsp);
		chk_resp(rsp, RESP_OKAY);
		chk_val(rd_d, 32'h00000006);
		axi_rd(REG_ADDR_LO, rd_d, rsp);
		chk_val(rd_d, 32'h44332211);
		axi_rd(REG_ADDR_HI, rd_d, rsp);
		chk_val(rd_d, 32'h00006655);
		axi_rd(REG_SUBSYS, rd_d, rsp);
		chk_val(rd_d, 32'h01015a3c);
		results;
	end
endmodule
`default_nettype wire
